// >>> src/exec_consts.vh
`ifndef EXEC_CONSTS_VH
`define EXEC_CONSTS_VH
`define OP_ADD 5'h00
`define OP_ADC 5'h01
`define OP_SUB 5'h02
`define OP_SUBTRACT_CONSTANT 5'h03
`define OP_SBC 5'h04
`define OP_SUBTRACT_CONST_WITH_BORROW 5'h05
`define OP_AND 5'h06
`define OP_AND_CONSTANT 5'h07
`define OP_OR 5'h08
`define OP_ORI 5'h09
`define OP_XOR 5'h0a
`define OP_SETB 5'h0b
`define OP_CLRB 5'h0c
`define OP_TST 5'h0d
`define OP_CPI 5'h0e
`define OP_COMPARE_SKIP_EQUAL 5'h0f
`define OP_SKRZ 5'h10
`define OP_SKRO 5'h11
`define OP_SKIZ 5'h12
`define OP_SKIO 5'h13
`define OP_IOSET 5'h14
`define OP_IOCLR 5'h15
`define OP_POINTER_JUMP 5'h16
`define OP_POINTER_CALL 5'h17
`define OP_IOWR 5'h18
`define OP_IORD 5'h19
`define ADDR_SPL 6'h3d
`define ADDR_SPH 6'h3e
`define ADDR_STATUS_FLAGS 6'h3f
`define ADDR_FLAGS 6'h1e
`define BIT_IO_MAX 6'h1f
`define STATUS_FLAGS_RESET 8'h00
`define SP_RESET 16'h0000
`define F_C 0
`define F_Z 1
`define F_N 2
`define F_V 3
`define F_S 4
`define F_H 5
`define F_T 6
`define F_I 7
`define CYC_POINTER_JUMP 3'h2
`define CYC_POINTER_CALL 3'h3
`define CYC_SKIP1 3'h2
`define CYC_SKIP2 3'h3
`endif

// >>> src/alu_core.v
`include "exec_consts.vh"
module alu_core (
  input wire [4:0] op_i,
  input wire [7:0] a_i,
  input wire [7:0] b_i,
  input wire [7:0] flags_i,
  output reg [7:0] res_o,
  output reg [7:0] flags_o,
  output reg write_o
);
  reg [8:0] sum;
  reg [4:0] low;
  reg cin;
  reg arith;
  reg sub;
  always @* begin
    cin = flags_i[`F_C];
    sum = 9'h000;
    low = 5'h00;
    arith = 1'b0;
    sub = 1'b0;
    res_o = a_i;
    write_o = 1'b1;
    flags_o = flags_i;
    case (op_i)
      `OP_ADD, `OP_ADC: begin
        arith = 1'b1;
        if (op_i == `OP_ADD) cin = 1'b0;
        sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
        low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin};
      end
      `OP_SUB, `OP_SUBTRACT_CONSTANT, `OP_SBC, `OP_SUBTRACT_CONST_WITH_BORROW, `OP_CPI: begin
        arith = 1'b1;
        sub = 1'b1;
        if (op_i == `OP_SUB || op_i == `OP_SUBTRACT_CONSTANT || op_i == `OP_CPI) cin = 1'b0;
        sum = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin};
        low = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin};
        if (op_i == `OP_CPI) write_o = 1'b0;
      end
      `OP_AND, `OP_AND_CONSTANT: res_o = a_i & b_i;
      `OP_OR, `OP_ORI, `OP_SETB: res_o = a_i | b_i;
      `OP_XOR: res_o = a_i ^ b_i;
      `OP_CLRB: res_o = a_i & ~b_i;
      `OP_TST: res_o = a_i & a_i;
      default: write_o = 1'b0;
    endcase
    if (arith) begin
      res_o = sum[7:0];
      flags_o[`F_C] = sum[8];
      flags_o[`F_H] = low[4];
      if (sub)
        flags_o[`F_V] = (a_i[7] & ~b_i[7] & ~res_o[7]) | (~a_i[7] & b_i[7] & res_o[7]);
      else
        flags_o[`F_V] = (a_i[7] & b_i[7] & ~res_o[7]) | (~a_i[7] & ~b_i[7] & res_o[7]);
    end else if (write_o) begin
      flags_o[`F_V] = 1'b0;
    end
    if (arith || write_o) begin
      flags_o[`F_Z] = (res_o == 8'h00);
      flags_o[`F_N] = res_o[7];
      flags_o[`F_S] = res_o[7] ^ flags_o[`F_V];
    end
  end
endmodule // alu_core

// >>> src/skip_decider.v
`include "exec_consts.vh"
module skip_decider (
  input wire [4:0] op_i,
  input wire [7:0] a_i,
  input wire [7:0] b_i,
  input wire [2:0] bit_i,
  input wire [7:0] io_i,
  input wire next_two_word_i,
  output reg skip_o,
  output reg [2:0] cycles_o
);
  always @* begin
    case (op_i)
      `OP_COMPARE_SKIP_EQUAL: skip_o = (a_i == b_i);
      `OP_SKRZ: skip_o = ~a_i[bit_i];
      `OP_SKRO: skip_o = a_i[bit_i];
      `OP_SKIZ: skip_o = ~io_i[bit_i];
      `OP_SKIO: skip_o = io_i[bit_i];
      default: skip_o = 1'b0;
    endcase
    if (!skip_o)
      cycles_o = 3'h1;
    else if (next_two_word_i)
      cycles_o = `CYC_SKIP2;
    else
      cycles_o = `CYC_SKIP1;
  end
endmodule // skip_decider

// >>> src/exec_unit.v
`include "exec_consts.vh"
module exec_unit #(
  parameter NREG = 16
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire start_i,
  input wire [4:0] op_i,
  input wire [3:0] rd_i,
  input wire [3:0] rr_i,
  input wire [7:0] imm_i,
  input wire [5:0] io_addr_i,
  input wire [2:0] bit_i,
  input wire next_two_word_i,
  input wire [15:0] pc_i,
  input wire flag_event_i,
  output reg busy_o,
  output reg done_o,
  output reg illegal_o,
  output reg pc_load_o,
  output reg [21:0] pc_o,
  output reg [1:0] pc_skip_o,
  output reg [15:0] ret_addr_o,
  output reg [7:0] status_flags_o,
  output reg [15:0] stack_pointer_o,
  output reg [7:0] io_rdata_o,
  output reg [7:0] event_flags_o
);
  localparam S_IDLE = 2'b01;
  localparam S_WAIT = 2'b10;
  reg [7:0] regs [0:NREG-1];
  reg [7:0] status_flags;
  reg [7:0] stack_pointer_low;
  reg [7:0] stack_pointer_high;
  reg [7:0] event_flags;
  reg [1:0] state;
  reg [2:0] wait_cnt;
  // pc_skip_o is gone before a long skip ends, so the kind of wait is kept here
  reg jump_pend;
  wire [15:0] sp_init = `SP_RESET;
  wire [7:0] a_val = regs[rd_i];
  wire [7:0] r_val = regs[rr_i];
  wire imm_op = (op_i == `OP_SUBTRACT_CONSTANT) || (op_i == `OP_SUBTRACT_CONST_WITH_BORROW) || (op_i == `OP_AND_CONSTANT) ||
    (op_i == `OP_ORI) || (op_i == `OP_SETB) || (op_i == `OP_CLRB) || (op_i == `OP_CPI);
  wire [7:0] b_val = imm_op ? imm_i : r_val;
  wire [7:0] alu_res;
  wire [7:0] alu_flags;
  wire alu_write;
  wire skip;
  wire [2:0] skip_cycles;
  wire [15:0] z_ptr = {regs[NREG-1], regs[NREG-2]};
  wire bit_ok = (io_addr_i <= `BIT_IO_MAX);
  wire [7:0] bit_mask = 8'h01 << bit_i;
  reg [7:0] io_val;
  reg [7:0] next_status;
  reg [7:0] next_events;
  wire go = start_i && (state == S_IDLE);
  wire cs_op = (op_i == `OP_COMPARE_SKIP_EQUAL) || (op_i == `OP_SKRZ) || (op_i == `OP_SKRO);
  wire io_skip = (op_i == `OP_SKIZ) || (op_i == `OP_SKIO);
  wire io_bit = (op_i == `OP_IOSET) || (op_i == `OP_IOCLR) || io_skip;
  integer i;

  alu_core u_alu (
    .op_i(op_i),
    .a_i(a_val),
    .b_i(b_val),
    .flags_i(status_flags),
    .res_o(alu_res),
    .flags_o(alu_flags),
    .write_o(alu_write)
  );

  skip_decider u_skip (
    .op_i(op_i),
    .a_i(a_val),
    .b_i(r_val),
    .bit_i(bit_i),
    .io_i(io_val),
    .next_two_word_i(next_two_word_i),
    .skip_o(skip),
    .cycles_o(skip_cycles)
  );

  always @* begin
    case (io_addr_i)
      `ADDR_SPL: io_val = stack_pointer_low;
      `ADDR_SPH: io_val = stack_pointer_high;
      `ADDR_STATUS_FLAGS: io_val = status_flags;
      `ADDR_FLAGS: io_val = event_flags;
      default: io_val = 8'h00;
    endcase
  end

  // event flags: hardware set wins over a software clear in the same cycle
  always @* begin
    next_events = event_flags;
    if (go && bit_ok && io_addr_i == `ADDR_FLAGS) begin
      if (op_i == `OP_IOSET)
        next_events = event_flags & ~bit_mask;
      else if (op_i == `OP_IOWR)
        next_events = event_flags & ~imm_i;
    end
    if (flag_event_i)
      next_events = next_events | 8'h01;
  end

  always @* begin
    next_status = status_flags;
    if (go) begin
      if (alu_write || op_i == `OP_CPI)
        next_status = alu_flags;
      else if (op_i == `OP_IOWR && io_addr_i == `ADDR_STATUS_FLAGS)
        next_status = imm_i;
      else if (io_addr_i == `ADDR_STATUS_FLAGS && op_i == `OP_IOSET)
        next_status = status_flags;
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < NREG; i = i + 1)
        regs[i] <= 8'h00;
      status_flags <= `STATUS_FLAGS_RESET;
      stack_pointer_low <= sp_init[7:0];
      stack_pointer_high <= sp_init[15:8];
      jump_pend <= 1'b0;
      event_flags <= 8'h00;
      state <= S_IDLE;
      wait_cnt <= 3'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      pc_load_o <= 1'b0;
      pc_o <= 22'h000000;
      pc_skip_o <= 2'h0;
      ret_addr_o <= 16'h0000;
      status_flags_o <= `STATUS_FLAGS_RESET;
      stack_pointer_o <= `SP_RESET;
      io_rdata_o <= 8'h00;
      event_flags_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      pc_load_o <= 1'b0;
      pc_skip_o <= 2'h0;
      illegal_o <= 1'b0;
      status_flags <= next_status;
      event_flags <= next_events;
      case (state)
        S_IDLE: begin
          if (start_i) begin
            if (alu_write)
              regs[rd_i] <= alu_res;
            if (io_bit && !bit_ok)
              illegal_o <= 1'b1;
            if (op_i == `OP_IOWR && io_addr_i == `ADDR_SPL)
              stack_pointer_low <= imm_i;
            if (op_i == `OP_IOWR && io_addr_i == `ADDR_SPH)
              stack_pointer_high <= imm_i;
            if (op_i == `OP_IORD)
              io_rdata_o <= io_val;
            if (op_i == `OP_POINTER_JUMP || op_i == `OP_POINTER_CALL) begin
              pc_o <= {6'h00, z_ptr};
              ret_addr_o <= pc_i + 16'h0001;
              wait_cnt <= (op_i == `OP_POINTER_JUMP) ? `CYC_POINTER_JUMP - 3'h1 : `CYC_POINTER_CALL - 3'h1;
              state <= S_WAIT;
              busy_o <= 1'b1;
              jump_pend <= 1'b1;
            end else if ((cs_op || (io_skip && bit_ok)) && skip) begin
              pc_skip_o <= next_two_word_i ? 2'h3 : 2'h2;
              jump_pend <= 1'b0;
              wait_cnt <= skip_cycles - 3'h1;
              state <= S_WAIT;
              busy_o <= 1'b1;
            end else begin
              done_o <= 1'b1;
            end
          end
        end
        S_WAIT: begin
          wait_cnt <= wait_cnt - 3'h1;
          if (wait_cnt == 3'h1) begin
            state <= S_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            pc_load_o <= jump_pend;
          end
        end
        default: state <= S_IDLE;
      endcase
      status_flags_o <= next_status;
      stack_pointer_o <= {stack_pointer_high, stack_pointer_low};
      event_flags_o <= next_events;
    end
  end
endmodule // exec_unit

// >>> tb/exec_checker.sv
`include "exec_consts.vh"
module exec_checker (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire start_i,
  input wire [4:0] op_i,
  input wire [5:0] io_addr_i,
  input wire flag_event_i,
  input wire busy_o,
  input wire done_o,
  input wire illegal_o,
  input wire pc_load_o,
  input wire [21:0] pc_o,
  input wire [1:0] pc_skip_o,
  input wire [7:0] status_flags_o,
  input wire [7:0] event_flags_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire go = start_i && !busy_o;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_one_cycle;
    go && op_i <= `OP_CPI |=> done_o;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("alu op late");
  property p_jump;
    go && op_i == `OP_POINTER_JUMP |=> busy_o && !done_o ##1 done_o && pc_load_o && !busy_o;
  endproperty
  a_jump: assert property (p_jump) else $error("jump timing wrong");
  property p_jump_hi;
    go && op_i == `OP_POINTER_JUMP |-> ##2 pc_o[21:16] == 6'h00;
  endproperty
  a_jump_hi: assert property (p_jump_hi) else $error("jump upper pc bits set");
  property p_call;
    go && op_i == `OP_POINTER_CALL |=> busy_o [*2] ##1 done_o && pc_load_o;
  endproperty
  a_call: assert property (p_call) else $error("call timing wrong");
  property p_branch_flags;
    go && (op_i == `OP_POINTER_JUMP || op_i == `OP_POINTER_CALL) |=> $stable(status_flags_o) [*2];
  endproperty
  a_branch_flags: assert property (p_branch_flags) else $error("flags moved");
  property p_bit_range;
    go && op_i >= `OP_SKIZ && op_i <= `OP_IOCLR && io_addr_i > `BIT_IO_MAX |=> illegal_o;
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("high bit access taken");
  property p_logic_ch;
    go && op_i >= `OP_AND && op_i <= `OP_TST |=>
      status_flags_o[`F_C] == $past(status_flags_o[`F_C]) &&
      status_flags_o[`F_H] == $past(status_flags_o[`F_H]);
  endproperty
  a_logic_ch: assert property (p_logic_ch) else $error("logic op moved carry");
  property p_sign;
    go && op_i <= `OP_CPI |=>
      status_flags_o[`F_S] == (status_flags_o[`F_N] ^ status_flags_o[`F_V]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");
  property p_event;
    flag_event_i |=> event_flags_o[0];
  endproperty
  a_event: assert property (p_event) else $error("event flag not set");
  property p_skip_no_load;
    pc_skip_o != 2'h0 |=> !pc_load_o ##1 !pc_load_o;
  endproperty
  a_skip_no_load: assert property (p_skip_no_load) else $error("skip loaded pc");
  c_jump: cover property (go && op_i == `OP_POINTER_JUMP);
  c_call: cover property (go && op_i == `OP_POINTER_CALL);
  c_illegal: cover property (illegal_o);
endmodule // exec_checker
bind exec_unit exec_checker exec_checker_inst (.clk_sys_i, .rst_n_i, .start_i, .op_i,
  .io_addr_i, .flag_event_i, .busy_o, .done_o, .illegal_o, .pc_load_o, .pc_o, .pc_skip_o,
  .status_flags_o, .event_flags_o);

// >>> tb/core_alu_branch_execute_tb.sv
`include "exec_consts.vh"
`define CHK(n, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); \
  end \
end
module core_alu_branch_execute_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'h0, rst_n_i = 1'h0, start_i = 1'h0;
  logic next_two_word_i = 1'h0, flag_event_i = 1'h0;
  logic [4:0] op_i = 5'h00;
  logic [3:0] rd_i = 4'h0, rr_i = 4'h0;
  logic [7:0] imm_i = 8'h00;
  logic [5:0] io_addr_i = 6'h00;
  logic [2:0] bit_i = 3'h0;
  logic [15:0] pc_i = 16'h0000;
  logic busy_o, done_o, illegal_o, pc_load_o;
  logic [21:0] pc_o;
  logic [1:0] pc_skip_o, skw;
  logic [15:0] ret_addr_o, stack_pointer_o;
  logic [7:0] status_flags_o, io_rdata_o, event_flags_o, fl;
  logic ill, ld;
  int cyc = 0;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  exec_unit exec_unit_inst (.clk_sys_i, .rst_n_i, .start_i, .op_i, .rd_i, .rr_i, .imm_i,
    .io_addr_i, .bit_i, .next_two_word_i, .pc_i, .flag_event_i, .busy_o, .done_o,
    .illegal_o, .pc_load_o, .pc_o, .pc_skip_o, .ret_addr_o, .status_flags_o,
    .stack_pointer_o, .io_rdata_o, .event_flags_o);
  task tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // entered just after a rising edge; ends one idle edge after the op completes
  task ex(input [4:0] o, input [3:0] d, input [3:0] r, input [7:0] k, input [5:0] a,
    input [2:0] b, input t);
    int n;
    op_i = o;
    rd_i = d;
    rr_i = r;
    imm_i = k;
    io_addr_i = a;
    bit_i = b;
    next_two_word_i = t;
    start_i = 1'h1;
    @(posedge clk_sys_i);
    #1 start_i = 1'h0;
    // pulses stand for one cycle only, so they are caught as they appear
    skw = pc_skip_o;
    n = 0;
    while (done_o !== 1'h1 && n < 6) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
    ill = illegal_o;
    ld = pc_load_o;
    cyc = n + 1;
    // an idle edge keeps start_i low between back-to-back calls
    @(posedge clk_sys_i);
    #1;
  endtask
  task alu(input [4:0] o, input [3:0] d, input [3:0] r, input [7:0] k, input [7:0] e);
    ex(o, d, r, k, 6'h00, 3'h0, 1'h0);
    `CHK("flags", e, status_flags_o)
    `CHK("alu cycles", 1, cyc)
  endtask
  task sk(input [4:0] o, input [3:0] d, input [5:0] a, input [2:0] b, input t,
    input [1:0] e);
    ex(o, d, d, 8'h00, a, b, t);
    `CHK("skip", e, skw)
    `CHK("skip cyc", e == 2'h0 ? 3'h1 : e == 2'h2 ? `CYC_SKIP1 : `CYC_SKIP2, cyc)
    `CHK("skip load", 1'h0, ld)
  endtask
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    #1 rst_n_i = 1'h1;
    `CHK("status_flags rst", `STATUS_FLAGS_RESET, status_flags_o)
    `CHK("sp rst", `SP_RESET, stack_pointer_o)
    // registers start at zero, so subtract-constant loads negated values
    alu(`OP_SUBTRACT_CONSTANT, 4'h1, 4'h0, 8'h01, 8'h35);
    alu(`OP_ADD, 4'h2, 4'h1, 8'h00, 8'h14);
    alu(`OP_ADD, 4'h2, 4'h1, 8'h00, 8'h35);
    alu(`OP_ADC, 4'h3, 4'h1, 8'h00, 8'h23);
    alu(`OP_SBC, 4'h4, 4'h0, 8'h00, 8'h35);
    alu(`OP_SUB, 4'h6, 4'h1, 8'h00, 8'h21);
    alu(`OP_SUBTRACT_CONST_WITH_BORROW, 4'h3, 4'h0, 8'h01, 8'h35);
    alu(`OP_AND_CONSTANT, 4'h2, 4'h0, 8'h0f, 8'h21);
    alu(`OP_OR, 4'h5, 4'h0, 8'h00, 8'h23);
    alu(`OP_AND, 4'h2, 4'h1, 8'h00, 8'h21);
    alu(`OP_ORI, 4'h5, 4'h0, 8'h80, 8'h35);
    alu(`OP_XOR, 4'h5, 4'h5, 8'h00, 8'h23);
    alu(`OP_SETB, 4'h5, 4'h0, 8'h01, 8'h21);
    alu(`OP_CLRB, 4'h5, 4'h0, 8'h01, 8'h23);
    alu(`OP_TST, 4'h1, 4'h0, 8'h00, 8'h35);
    alu(`OP_CPI, 4'h1, 4'h0, 8'hff, 8'h02);
    alu(`OP_CPI, 4'h1, 4'h0, 8'hff, 8'h02);
    sk(`OP_COMPARE_SKIP_EQUAL, 4'h1, 6'h00, 3'h0, 1'h0, 2'h2);
    ex(`OP_COMPARE_SKIP_EQUAL, 4'h1, 4'h2, 8'h00, 6'h00, 3'h0, 1'h0);
    `CHK("no skip", 2'h0, skw)
    sk(`OP_COMPARE_SKIP_EQUAL, 4'h5, 6'h00, 3'h0, 1'h1, 2'h3);
    sk(`OP_SKRZ, 4'h2, 6'h00, 3'h0, 1'h0, 2'h2);
    sk(`OP_SKRZ, 4'h2, 6'h00, 3'h1, 1'h0, 2'h0);
    sk(`OP_SKRO, 4'h2, 6'h00, 3'h1, 1'h1, 2'h3);
    sk(`OP_SKRO, 4'h2, 6'h00, 3'h0, 1'h0, 2'h0);
    alu(`OP_SUBTRACT_CONSTANT, 4'hf, 4'h0, 8'hee, 8'h21);
    alu(`OP_SUBTRACT_CONSTANT, 4'he, 4'h0, 8'hcc, 8'h21);
    fl = status_flags_o;
    ex(`OP_POINTER_JUMP, 4'h0, 4'h0, 8'h00, 6'h00, 3'h0, 1'h0);
    `CHK("jump pc", 22'h001234, pc_o)
    `CHK("jump flags", fl, status_flags_o)
    `CHK("jump cycles", `CYC_POINTER_JUMP, cyc)
    `CHK("jump load", 1'h1, ld)
    pc_i = 16'h0100;
    ex(`OP_POINTER_CALL, 4'h0, 4'h0, 8'h00, 6'h00, 3'h0, 1'h0);
    `CHK("call pc", 22'h001234, pc_o)
    `CHK("call ret", 16'h0101, ret_addr_o)
    `CHK("call flags", fl, status_flags_o)
    `CHK("call cycles", `CYC_POINTER_CALL, cyc)
    `CHK("call load", 1'h1, ld)
    flag_event_i = 1'h1;
    @(posedge clk_sys_i);
    #1 flag_event_i = 1'h0;
    sk(`OP_SKIO, 4'h0, `ADDR_FLAGS, 3'h0, 1'h0, 2'h2);
    ex(`OP_IOCLR, 4'h0, 4'h0, 8'h00, `ADDR_FLAGS, 3'h1, 1'h0);
    `CHK("evt kept", 1'h1, event_flags_o[0])
    flag_event_i = 1'h1;
    ex(`OP_IOSET, 4'h0, 4'h0, 8'h00, `ADDR_FLAGS, 3'h0, 1'h0);
    flag_event_i = 1'h0;
    `CHK("evt set wins", 1'h1, event_flags_o[0])
    ex(`OP_IOSET, 4'h0, 4'h0, 8'h00, `ADDR_FLAGS, 3'h0, 1'h0);
    `CHK("evt w1c", 1'h0, event_flags_o[0])
    sk(`OP_SKIZ, 4'h0, `ADDR_FLAGS, 3'h0, 1'h0, 2'h2);
    ex(`OP_IOSET, 4'h0, 4'h0, 8'h00, 6'h20, 3'h0, 1'h0);
    `CHK("illegal", 1'h1, ill)
    ex(`OP_IOWR, 4'h0, 4'h0, 8'ha5, `ADDR_STATUS_FLAGS, 3'h0, 1'h0);
    `CHK("status_flags wr", 8'ha5, status_flags_o)
    ex(`OP_IORD, 4'h0, 4'h0, 8'h00, `ADDR_STATUS_FLAGS, 3'h0, 1'h0);
    `CHK("status_flags rd", 8'ha5, io_rdata_o)
    ex(`OP_IOWR, 4'h0, 4'h0, 8'h5a, `ADDR_SPL, 3'h0, 1'h0);
    ex(`OP_IOWR, 4'h0, 4'h0, 8'hc3, `ADDR_SPH, 3'h0, 1'h0);
    `CHK("sp", 16'hc35a, stack_pointer_o)
    tally_and_finish();
  end
endmodule // core_alu_branch_execute_tb
